/* src/dssb_pkg.sv */
package dssb_pkg;
	// register select codes on both access views
	localparam logic SEL_VERSION = 1'h0;
	localparam logic SEL_STATUS  = 1'h1;

	// version register fields
	localparam int          VER_ARCH_LSB = 16;
	localparam int          VER_SEC_LSB  = 12;
	localparam logic [3:0]  VER_ARCH_VAL = 4'h2;
	localparam logic [3:0]  VER_SEC_VAL  = 4'h1;

	// status register field positions
	localparam int ST_BARRIER    = 19;
	localparam int ST_NONSECURE  = 18;
	localparam int ST_NOT_SPOBS  = 17;
	localparam int ST_NOT_SPINV  = 16;
	localparam int ST_MODE_LSB   = 14;
	localparam int ST_INT_DIS    = 11;
	localparam int ST_STK_UNDEF  = 8;
	localparam int ST_STK_IMPREC = 7;
	localparam int ST_STK_PREC   = 6;
	localparam int ST_METHOD_LSB = 2;

	// sticky flag indices
	localparam int STK_UNDEF  = 2;
	localparam int STK_IMPREC = 1;
	localparam int STK_PREC   = 0;
	localparam int STK_NUM    = 3;

	// reset values
	localparam logic        RST_BARRIER = 1'h0;
	localparam logic        RST_INT_DIS = 1'h0;
	localparam logic [1:0]  RST_MODE    = 2'h0;
	localparam logic [3:0]  RST_METHOD  = 4'h0;
	localparam logic [31:0] RST_RDATA   = 32'h0;

	// debug mode value meaning debug disabled
	localparam logic [1:0]  MODE_DISABLED = 2'h0;

	// debug entry method encodings
	localparam logic [3:0] ENT_REQUEST  = 4'h0;
	localparam logic [3:0] ENT_BREAK    = 4'h1;
	localparam logic [3:0] ENT_WATCH    = 4'h2;
	localparam logic [3:0] ENT_BKPT     = 4'h3;
	localparam logic [3:0] ENT_EXT_REQ  = 4'h4;
	localparam logic [3:0] ENT_VEC_CAT  = 4'h5;
endpackage : dssb_pkg

/* src/dssb_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pin levels
module dssb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk, // core clock
	input  wire logic             rst_n,   // synchronous reset
	input  wire logic [WIDTH-1:0] async_i, // raw pin levels
	output logic      [WIDTH-1:0] sync_q   // resynchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} dssb_sync_t;

	dssb_sync_t q;
	dssb_sync_t d;

	// first stage feeds only the second stage
	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_q = q.s2;
endmodule : dssb_sync

/* src/dssb_sticky.sv */
`timescale 1ns/100ps
// sticky flag: hardware set beats a read clear in the same cycle
module dssb_sticky (
	input  wire logic sys_clk, // core clock
	input  wire logic rst_n,   // synchronous reset
	input  wire logic set_i,   // qualified event
	input  wire logic clr_i,   // clear on read
	output logic      flag_q   // held flag
);
	typedef struct packed {
		logic flag;
	} dssb_sticky_t;

	dssb_sticky_t q;
	dssb_sticky_t d;

	// set wins so no event is lost to a racing read
	always_comb begin
		d      = q;
		d.flag = set_i | (q.flag & ~clr_i);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign flag_q = q.flag;
endmodule : dssb_sticky

/* src/dssb_top.sv */
// Contract
// RQ1 - version field reads 0x2 both views
// RQ2 - security field reads 0x1 both views
// RQ3 - barrier bit set by barrier in debug
// RQ4 - no imprecise abort taken while barrier set
// RQ5 - nonsecure status only when ns, not monitor
// RQ6 - bit 17 inverts secure observe permit
// RQ7 - bit 16 inverts secure invasive permit
// RQ8 - interrupt disable blocks irq and fiq
// RQ9 - disable ignored when mode off or permit low
// RQ10 - undefined sticky set only in debug state
// RQ11 - external status read clears undefined sticky
// RQ12 - imprecise sticky set only in debug state
// RQ13 - imprecise sticky cleared after read
// RQ14 - precise sticky set only in debug state
// RQ15 - entry method core writable, external read only
// RQ16 - bits 19,18 read only; 11 external write
// RQ17 - four permits gate invasive and observe debug
// RQ18 - entry method encodings as defined
// RQ19 - writes to read-only bits are ignored
`timescale 1ns/100ps
module dssb_top (
	input  wire logic        sys_clk,          // core clock, 40 MHz
	input  wire logic        rst_n,            // synchronous reset, active low
	// core view
	input  wire logic        core_rd_en,       // core read strobe
	input  wire logic        core_wr_en,       // core write strobe
	input  wire logic        core_sel,         // 0 version, 1 status
	input  wire logic [31:0] core_wdata,       // core write data
	output logic      [31:0] core_rdata_q,     // core read data
	output logic             core_rvalid_q,    // core read data valid
	// external debugger view
	input  wire logic        ext_rd_en,        // external read strobe
	input  wire logic        ext_wr_en,        // external write strobe
	input  wire logic        ext_sel,          // 0 version, 1 status
	input  wire logic [31:0] ext_wdata,        // external write data
	output logic      [31:0] ext_rdata_q,      // external read data
	output logic             ext_rvalid_q,     // external read data valid
	// debug permit pins
	input  wire logic        invasive_debug_permit,       // pin
	input  wire logic        observation_debug_permit,    // pin
	input  wire logic        secure_priv_invasive_permit, // pin
	input  wire logic        secure_priv_observe_permit,  // pin
	// core state, same clock
	input  wire logic        in_debug_state,   // core halted in debug
	input  wire logic        debug_entry,      // pulse on entering debug
	input  wire logic [3:0]  entry_method,     // cause of debug entry
	input  wire logic        data_sync_barrier,// barrier executed
	input  wire logic        nonsecure_world_bit, // world bit
	input  wire logic        monitor_mode,     // core in monitor mode
	input  wire logic        priv_mode,        // core in privileged mode
	input  wire logic        su_invasive_en,   // allow secure user invasive
	input  wire logic        su_observe_en,    // allow secure user observe
	input  wire logic        undef_exc,        // undefined instr exception
	input  wire logic        imprecise_abort,  // imprecise abort returned
	input  wire logic        precise_abort,    // precise data abort
	// interrupt pins
	input  wire logic        irq_pin,          // raw irq
	input  wire logic        fiq_pin,          // raw fiq
	// results
	output logic             irq_q,            // gated irq to core
	output logic             fiq_q,            // gated fiq to core
	output logic             imp_abort_take_q, // imprecise abort taken
	output logic             invasive_ok_q,    // invasive debug allowed
	output logic             observe_ok_q      // observation allowed
);
	typedef struct packed {
		logic [31:0] core_rdata;
		logic        core_rvalid;
		logic [31:0] ext_rdata;
		logic        ext_rvalid;
		logic        barrier;
		logic        int_dis;
		logic [1:0]  mode;
		logic [3:0]  method;
		logic        irq;
		logic        fiq;
		logic        imp_take;
		logic        inv_ok;
		logic        obs_ok;
	} dssb_state_t;

	dssb_state_t q;
	dssb_state_t d;

	logic [5:0]                  pins_s;
	logic                        invasive_debug_permit_s;
	logic                        observation_debug_permit_s;
	logic                        spi_s;
	logic                        spn_s;
	logic                        irq_s;
	logic                        fiq_s;
	logic [dssb_pkg::STK_NUM-1:0] stk_set;
	logic [dssb_pkg::STK_NUM-1:0] stk_q;
	logic                        ext_stat_rd;
	logic                        ns_status;
	logic                        int_mask;
	logic                        secure;
	logic [31:0]                 version_word;
	logic [31:0]                 status_word;

	// every pin crosses two flops before use
	dssb_sync #(
		.WIDTH(6)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.async_i({invasive_debug_permit, observation_debug_permit,
			secure_priv_invasive_permit, secure_priv_observe_permit,
			irq_pin, fiq_pin}),
		.sync_q (pins_s)
	);

	assign {invasive_debug_permit_s, observation_debug_permit_s, spi_s, spn_s, irq_s, fiq_s} = pins_s;

	// sticky events only count while halted in debug
	assign stk_set[dssb_pkg::STK_UNDEF]  = in_debug_state & undef_exc;       // RQ10
	assign stk_set[dssb_pkg::STK_IMPREC] = in_debug_state & imprecise_abort; // RQ12
	assign stk_set[dssb_pkg::STK_PREC]   = in_debug_state & precise_abort;   // RQ14

	// only the debugger's status read clears, core reads leave flags alone
	assign ext_stat_rd = ext_rd_en & (ext_sel == dssb_pkg::SEL_STATUS); // RQ11 RQ13

	// one sticky cell per flag
	generate
		for (genvar i = 0; i < dssb_pkg::STK_NUM; i++) begin : g_stk
			dssb_sticky u_stk (
				.sys_clk(sys_clk),
				.rst_n  (rst_n),
				.set_i  (stk_set[i]),
				.clr_i  (ext_stat_rd),
				.flag_q (stk_q[i])
			);
		end
	endgenerate

	// secure whenever world bit low or in monitor
	assign ns_status = nonsecure_world_bit & ~monitor_mode; // RQ5
	assign secure    = ~ns_status;

	// disable only bites with debug on and the permit high
	assign int_mask = q.int_dis & (q.mode != dssb_pkg::MODE_DISABLED) & invasive_debug_permit_s; // RQ8 RQ9

	// read-only identification word
	always_comb begin
		version_word = '0;
		version_word[dssb_pkg::VER_ARCH_LSB +: 4] = dssb_pkg::VER_ARCH_VAL; // RQ1
		version_word[dssb_pkg::VER_SEC_LSB +: 4]  = dssb_pkg::VER_SEC_VAL;  // RQ2
	end

	// status word, unlisted bits read zero
	always_comb begin
		status_word = '0;
		status_word[dssb_pkg::ST_BARRIER]         = q.barrier;
		status_word[dssb_pkg::ST_NONSECURE]       = ns_status; // RQ5
		status_word[dssb_pkg::ST_NOT_SPOBS]       = ~spn_s;    // RQ6
		status_word[dssb_pkg::ST_NOT_SPINV]       = ~spi_s;    // RQ7
		status_word[dssb_pkg::ST_MODE_LSB +: 2]   = q.mode;
		status_word[dssb_pkg::ST_INT_DIS]         = q.int_dis;
		status_word[dssb_pkg::ST_STK_UNDEF]       = stk_q[dssb_pkg::STK_UNDEF];
		status_word[dssb_pkg::ST_STK_IMPREC]      = stk_q[dssb_pkg::STK_IMPREC];
		status_word[dssb_pkg::ST_STK_PREC]        = stk_q[dssb_pkg::STK_PREC];
		status_word[dssb_pkg::ST_METHOD_LSB +: 4] = q.method;
	end

	// next state of all registered logic
	always_comb begin
		d = q;
		// read data shows the word before any clear
		d.core_rvalid = core_rd_en;
		d.ext_rvalid  = ext_rd_en;
		if (core_rd_en) begin
			d.core_rdata = (core_sel == dssb_pkg::SEL_STATUS) ? status_word : version_word;
		end
		if (ext_rd_en) begin
			d.ext_rdata = (ext_sel == dssb_pkg::SEL_STATUS) ? status_word : version_word;
		end
		// barrier flag lives only for the current debug session
		d.barrier = in_debug_state & (q.barrier | data_sync_barrier); // RQ3
		if (debug_entry && !data_sync_barrier) begin
			d.barrier = dssb_pkg::RST_BARRIER; // RQ3
		end
		// core may write only the entry method field
		if (core_wr_en && core_sel == dssb_pkg::SEL_STATUS) begin
			d.method = core_wdata[dssb_pkg::ST_METHOD_LSB +: 4]; // RQ15 RQ19
		end
		// hardware capture of the entry cause beats a core write
		if (debug_entry) begin
			d.method = entry_method; // RQ18
		end
		// debugger may write interrupt disable and mode, nothing else
		if (ext_wr_en && ext_sel == dssb_pkg::SEL_STATUS) begin
			d.int_dis = ext_wdata[dssb_pkg::ST_INT_DIS];       // RQ16 RQ19
			d.mode    = ext_wdata[dssb_pkg::ST_MODE_LSB +: 2]; // RQ19
		end
		// interrupts pass through one flop, gated by the disable
		d.irq = irq_s & ~int_mask; // RQ8
		d.fiq = fiq_s & ~int_mask; // RQ8
		d.imp_take = imprecise_abort & ~q.barrier; // RQ4
		// secure user debug follows priv permits unless widened
		d.inv_ok = invasive_debug_permit_s & (~secure | spi_s | (~priv_mode & su_invasive_en)); // RQ17
		d.obs_ok = (invasive_debug_permit_s | observation_debug_permit_s)
			& (~secure | spi_s | spn_s | (~priv_mode & su_observe_en)); // RQ17
	end

	// single state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q             <= '0;
			q.core_rdata  <= dssb_pkg::RST_RDATA;
			q.ext_rdata   <= dssb_pkg::RST_RDATA;
			q.barrier     <= dssb_pkg::RST_BARRIER; // RQ16
			q.int_dis     <= dssb_pkg::RST_INT_DIS; // RQ16
			q.mode        <= dssb_pkg::RST_MODE;
			q.method      <= dssb_pkg::RST_METHOD;
		end else begin
			q <= d;
		end
	end

	assign core_rdata_q     = q.core_rdata;
	assign core_rvalid_q    = q.core_rvalid;
	assign ext_rdata_q      = q.ext_rdata;
	assign ext_rvalid_q     = q.ext_rvalid;
	assign irq_q            = q.irq;
	assign fiq_q            = q.fiq;
	assign imp_abort_take_q = q.imp_take;
	assign invasive_ok_q    = q.inv_ok;
	assign observe_ok_q     = q.obs_ok;

	// checks on the design's own outputs and state
	sequence s_ext_ver_rd;
		ext_rd_en && ext_sel == dssb_pkg::SEL_VERSION;
	endsequence

	sequence s_ext_stat_rd;
		ext_rd_en && ext_sel == dssb_pkg::SEL_STATUS;
	endsequence

	sequence s_core_stat_wr;
		core_wr_en && core_sel == dssb_pkg::SEL_STATUS;
	endsequence

	sequence s_core_ver_rd;
		core_rd_en && core_sel == dssb_pkg::SEL_VERSION;
	endsequence

	a_version_fields: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1 RQ2
		s_ext_ver_rd |=> ext_rvalid_q && ext_rdata_q[19:16] == 4'h2
			&& ext_rdata_q[15:12] == 4'h1)
		else $error("version fields wrong on external read");

	a_barrier_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
		in_debug_state && data_sync_barrier |=> q.barrier)
		else $error("barrier bit not set after barrier in debug");

	a_barrier_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
		!in_debug_state |=> !q.barrier)
		else $error("barrier bit set outside debug state");

	a_imp_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
		q.barrier && imprecise_abort |=> !imp_abort_take_q)
		else $error("imprecise abort taken while barrier bit set");

	a_imp_passes: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
		!q.barrier && imprecise_abort |=> imp_abort_take_q)
		else $error("imprecise abort dropped with barrier bit clear");

	a_ns_status: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5
		s_ext_stat_rd |=> ext_rdata_q[18] == ($past(nonsecure_world_bit) && !$past(monitor_mode)))
		else $error("nonsecure status bit wrong");

	a_permit_invert: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6 RQ7
		s_ext_stat_rd |=> ext_rdata_q[17] == !$past(spn_s) && ext_rdata_q[16] == !$past(spi_s))
		else $error("permit inverse bits wrong");

	a_irq_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8 RQ9
		q.int_dis && q.mode != 2'h0 && invasive_debug_permit_s |=> !irq_q && !fiq_q)
		else $error("interrupt passed while disabled");

	a_irq_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
		irq_s && (q.mode == 2'h0 || !invasive_debug_permit_s) |=> irq_q)
		else $error("interrupt blocked with disable not in force");

	a_undef_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		in_debug_state && undef_exc |=> stk_q[2] [*1] ##1 1'b1)
		else $error("undefined sticky not set in debug");

	a_undef_outside: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		!stk_q[2] && !(in_debug_state && undef_exc) |=> !stk_q[2])
		else $error("undefined sticky set outside debug state");

	a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11 RQ13
		s_ext_stat_rd ##0 (!in_debug_state) |=> stk_q == 3'h0)
		else $error("sticky flags survive external status read");

	a_prec_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
		in_debug_state && precise_abort |=> stk_q[0])
		else $error("precise sticky not set in debug");

	a_imp_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		in_debug_state && imprecise_abort |=> stk_q[1])
		else $error("imprecise sticky not set in debug");

	a_method_core: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
		s_core_stat_wr ##0 !debug_entry |=> q.method == $past(core_wdata[5:2]))
		else $error("core write to entry method lost");

	a_method_ext_ro: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15 RQ19
		!core_wr_en && !debug_entry |=> $stable(q.method))
		else $error("entry method changed without core write or entry");

	a_intdis_core_ro: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ16 RQ19
		!(ext_wr_en && ext_sel == dssb_pkg::SEL_STATUS) |=> $stable(q.int_dis))
		else $error("interrupt disable changed without external write");

	a_entry_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ18
		debug_entry |=> q.method == $past(entry_method))
		else $error("entry cause not captured");

	a_invasive_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
		!invasive_debug_permit_s |=> !invasive_ok_q)
		else $error("invasive debug allowed with permit low");

	a_secpriv_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
		!ns_status && priv_mode && !spi_s && !spn_s |=> !invasive_ok_q && !observe_ok_q)
		else $error("secure privileged debug allowed without permits");

	a_core_version: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1 RQ2
		s_core_ver_rd |=> core_rvalid_q && core_rdata_q[19:16] == 4'h2
			&& core_rdata_q[15:12] == 4'h1)
		else $error("version fields wrong on core read");

	a_barrier_entry: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
		debug_entry && !data_sync_barrier |=> !q.barrier)
		else $error("barrier bit survives a fresh debug entry");

	a_fiq_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
		fiq_s && (q.mode == 2'h0 || !invasive_debug_permit_s) |=> fiq_q)
		else $error("fast interrupt blocked with disable not in force");

	a_mode_core_ro: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ19
		!(ext_wr_en && ext_sel == dssb_pkg::SEL_STATUS) |=> $stable(q.mode))
		else $error("mode field changed without external write");
endmodule : dssb_top

/* bench/dssb_dbg_model.sv */
`timescale 1ns/100ps
// external debugger: one-cycle strobes launched on the falling edge
module dssb_dbg_model (
	input  wire logic        sys_clk,   // core clock
	output logic             ext_rd_en, // read strobe
	output logic             ext_wr_en, // write strobe
	output logic             ext_sel,   // register select
	output logic      [31:0] ext_wdata  // write data
);
	// idle bus at power up
	initial begin
		ext_rd_en = 1'h0;
		ext_wr_en = 1'h0;
		ext_sel   = 1'h0;
		ext_wdata = 32'h0;
	end

	// strobe covers exactly one rising edge; select flips once released
	task automatic rd(input logic sel);
		@(negedge sys_clk);
		ext_sel   = sel;
		ext_rd_en = 1'h1;
		@(negedge sys_clk);
		ext_rd_en = 1'h0;
		ext_sel   = ~sel;
	endtask : rd

	// released data turns to its inverse so a stale word never looks valid
	task automatic wr(input logic sel, input logic [31:0] d);
		@(negedge sys_clk);
		ext_sel   = sel;
		ext_wdata = d;
		ext_wr_en = 1'h1;
		@(negedge sys_clk);
		ext_wr_en = 1'h0;
		ext_wdata = ~d;
	endtask : wr
endmodule : dssb_dbg_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	localparam logic [31:0] MS  = 32'h000fc9fc;
	localparam logic [31:0] VM  = 32'h000ff000;
	localparam logic [31:0] VER = {12'h0, dssb_pkg::VER_ARCH_VAL, dssb_pkg::VER_SEC_VAL, 12'h0};
	logic        sys_clk, rst_n, core_rd_en, core_wr_en, core_sel, core_rvalid_q;
	logic        ext_rd_en, ext_wr_en, ext_sel, ext_rvalid_q;
	logic [31:0] core_wdata, core_rdata_q, ext_wdata, ext_rdata_q, w;
	logic        invasive_debug_permit, observation_debug_permit;
	logic        secure_priv_invasive_permit, secure_priv_observe_permit;
	logic        in_debug_state, nonsecure_world_bit, monitor_mode, priv_mode;
	logic        irq_pin, fiq_pin, irq_q, fiq_q, imp_abort_take_q;
	logic        invasive_ok_q, observe_ok_q, idis, su_invasive_en, su_observe_en;
	logic [3:0]  entry_method, meth;
	logic [4:0]  evs;
	logic [1:0]  mode;
	logic [63:0] cq[$], eq[$], e;
	int          failures, num_checks, i;

	dssb_top dut (
		.sys_clk, .rst_n, .core_rd_en, .core_wr_en, .core_sel, .core_wdata,
		.core_rdata_q, .core_rvalid_q, .ext_rd_en, .ext_wr_en, .ext_sel, .ext_wdata,
		.ext_rdata_q, .ext_rvalid_q, .invasive_debug_permit, .observation_debug_permit,
		.secure_priv_invasive_permit, .secure_priv_observe_permit, .in_debug_state,
		.debug_entry(evs[4]), .entry_method, .data_sync_barrier(evs[3]),
		.nonsecure_world_bit, .monitor_mode, .priv_mode, .su_invasive_en,
		.su_observe_en, .undef_exc(evs[0]), .imprecise_abort(evs[1]),
		.precise_abort(evs[2]), .irq_pin, .fiq_pin, .irq_q, .fiq_q, .imp_abort_take_q,
		.invasive_ok_q, .observe_ok_q
	);
	dssb_dbg_model dbg (.sys_clk, .ext_rd_en, .ext_wr_en, .ext_sel, .ext_wdata);

	// free-running core clock, 25 ns
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		num_checks++;
		// a zero mask marks an answer that no request asked for
		if (m == 32'h0 || (got & m) !== (exp & m)) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results;
		// a request still waiting for its answer is a failure too
		if (cq.size() + eq.size() != 0) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, cq.size() + eq.size(), 32'h0);
		end
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// expected status word from the bench's own view of the state
	function automatic logic [31:0] sv(input logic [2:0] stk, input logic b19);
		sv = {12'h0, b19, nonsecure_world_bit & ~monitor_mode, ~secure_priv_observe_permit,
			~secure_priv_invasive_permit, mode, 2'h0, idis, 2'h0, stk, meth, 2'h0};
	endfunction : sv

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wt

	// note first, then strobe, so the answer always finds its note
	task automatic crd(input logic s, input logic [31:0] x, input logic [31:0] m);
		cq.push_back({m, x});
		@(negedge sys_clk);
		core_sel   = s;
		core_rd_en = 1'h1;
		@(negedge sys_clk);
		core_rd_en = 1'h0;
	endtask : crd

	task automatic erd(input logic s, input logic [31:0] x, input logic [31:0] m);
		eq.push_back({m, x});
		dbg.rd(s);
	endtask : erd

	task automatic cwr(input logic [31:0] d);
		@(negedge sys_clk);
		core_sel   = 1'h1;
		core_wdata = d;
		core_wr_en = 1'h1;
		@(negedge sys_clk);
		core_wr_en = 1'h0;
		core_wdata = ~d;
	endtask : cwr

	task automatic pulse(input logic [4:0] v);
		@(negedge sys_clk);
		evs = v;
		@(negedge sys_clk);
		evs = 5'h0;
	endtask : pulse

	// answers are taken off the queue of their view, oldest first
	always @(negedge sys_clk) begin
		if (core_rvalid_q === 1'h1) begin
			e = (cq.size() != 0) ? cq.pop_front() : 64'h0;
			chk(core_rdata_q, e[31:0], e[63:32]);
		end
		if (ext_rvalid_q === 1'h1) begin
			e = (eq.size() != 0) ? eq.pop_front() : 64'h0;
			chk(ext_rdata_q, e[31:0], e[63:32]);
		end
	end

	// hang guard, several times the roughly 1700 cycles the run needs
	initial begin
		#(25 * 10000);
		failures++;
		results();
	end

	// main sequence
	initial begin
		{rst_n, core_rd_en, core_wr_en, core_sel, core_wdata} = '0;
		{in_debug_state, nonsecure_world_bit, monitor_mode, irq_pin, fiq_pin} = '0;
		{invasive_debug_permit, observation_debug_permit} = 2'h3;
		{secure_priv_invasive_permit, secure_priv_observe_permit} = 2'h3;
		{priv_mode, entry_method, evs, mode, idis, meth, failures, num_checks} = '0;
		{su_invasive_en, su_observe_en} = 2'h0;
		priv_mode = 1'h1;
		void'($urandom(32'h5d1c9ca8));
		wt(4);
		rst_n = 1'h1;
		wt(3);
		crd(1'h0, VER, VM);
		erd(1'h0, VER, VM);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		// every permit pattern in every world, privileged and user, widened or not
		for (i = 0; i < 256; i++) begin
			{su_invasive_en, su_observe_en} = i[7:6];
			priv_mode = ~i[5];
			{nonsecure_world_bit, invasive_debug_permit, observation_debug_permit,
				secure_priv_invasive_permit, secure_priv_observe_permit} = i[4:0];
			wt(4);
			chk(invasive_ok_q, i[3] & (|{i[4], i[1], i[5] & i[7]}), 32'h1);
			chk(observe_ok_q, (i[3] | i[2]) & (|{i[4], i[1:0], i[5] & i[6]}), 32'h1);
			crd(1'h1, sv(3'h0, 1'h0), MS);
		end
		monitor_mode = 1'h1;
		wt(3);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		{monitor_mode, nonsecure_world_bit} = 2'h0;
		{invasive_debug_permit, secure_priv_invasive_permit} = 2'h3;
		// random core writes: only the entry method field may change
		for (i = 0; i < 4; i++) begin
			w = $urandom;
			meth = w[5:2];
			cwr(w);
			erd(1'h1, sv(3'h0, 1'h0), MS);
		end
		w = $urandom;
		{mode, idis} = 3'h3;
		dbg.wr(1'h1, {w[31:16], mode, w[13:12], idis, w[10:0]});
		crd(1'h1, sv(3'h0, 1'h0), MS);
		{irq_pin, fiq_pin} = 2'h3;
		wt(5);
		chk({irq_q, fiq_q}, 32'h0, 32'h3);
		invasive_debug_permit = 1'h0;
		wt(5);
		chk({irq_q, fiq_q}, 32'h3, 32'h3);
		invasive_debug_permit = 1'h1;
		mode = 2'h0;
		dbg.wr(1'h1, {16'h0, mode, 2'h0, idis, 11'h0});
		wt(4);
		chk({irq_q, fiq_q}, 32'h3, 32'h3);
		{mode, idis} = 3'h2;
		dbg.wr(1'h1, {16'h0, mode, 2'h0, idis, 11'h0});
		wt(4);
		chk({irq_q, fiq_q}, 32'h3, 32'h3);
		{irq_pin, fiq_pin} = 2'h0;
		// each entry method code, captured on entry
		in_debug_state = 1'h1;
		for (i = 0; i < 6; i++) begin
			entry_method = i[3:0];
			meth = i[3:0];
			pulse(5'h10);
			erd(1'h1, sv(3'h0, 1'h0), MS);
		end
		pulse(5'h02);
		chk(imp_abort_take_q, 32'h1, 32'h1);
		erd(1'h1, sv(3'h2, 1'h0), MS);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		pulse(5'h08);
		erd(1'h1, sv(3'h0, 1'h1), MS);
		pulse(5'h02);
		chk(imp_abort_take_q, 32'h0, 32'h1);
		pulse(5'h05);
		crd(1'h1, sv(3'h7, 1'h1), MS);
		erd(1'h1, sv(3'h7, 1'h1), MS);
		erd(1'h1, sv(3'h0, 1'h1), MS);
		// leaving debug drops the barrier bit; events no longer stick
		in_debug_state = 1'h0;
		pulse(5'h07);
		chk(imp_abort_take_q, 32'h1, 32'h1);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		// a fresh entry forgets a barrier seen in the session before
		in_debug_state = 1'h1;
		pulse(5'h08);
		pulse(5'h10);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		// mid-run reset returns the writable fields to zero
		dbg.wr(1'h1, 32'h0000c800);
		rst_n = 1'h0;
		wt(2);
		rst_n = 1'h1;
		{mode, idis, meth} = '0;
		wt(3);
		erd(1'h1, sv(3'h0, 1'h0), MS);
		wt(3);
		results();
	end
endmodule : tb_top
